/* File: tb/exvp_checker.sv */
// checker: vector port and wake-up relations of exvp_top
// assumes a bind onto exvp_top, one clock clk_i, synchronous rst_i
`timescale 1ns/1ps
`default_nettype none
module exvp_checker #(
    parameter int NUM_IRQ = 56
) (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               por_rst_req_i,
    input wire logic               clkmon_rst_req_i,
    input wire logic               wdog_rst_req_i,
    input wire logic               trap_req_i,
    input wire logic               soft_irq_req_i,
    input wire logic               die_link_err_i,
    input wire logic               die_link_irq_i,
    input wire logic [NUM_IRQ-1:0] irq_i,
    input wire logic               i_mask_i,
    input wire logic               x_mask_i,
    input wire logic               debug_firmware_mode_i,
    input wire logic               vec_req_i,
    input wire logic [15:0]        vec_addr_o,
    input wire logic               vec_ack_o,
    input wire logic               wake_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic rst_any;
    logic any_irq;
    assign take    = vec_req_i && !vec_ack_o;
    assign rst_any = por_rst_req_i || clkmon_rst_req_i || wdog_rst_req_i;
    assign any_irq = trap_req_i || soft_irq_req_i || die_link_err_i || die_link_irq_i || (|irq_i);
    ack_resp_a: assert property (take |=> vec_ack_o) else $error("strobe not acknowledged");
    ack_drop_a: assert property (vec_ack_o && !vec_req_i |=> !vec_ack_o) else $error("ack outlived strobe");
    addr_hold_a: assert property (vec_ack_o && vec_req_i |=> $stable(vec_addr_o)) else $error("vector moved");
    por_vec_a: assert property (take && por_rst_req_i |=> vec_addr_o == 16'hFFFE) else $error("bad por vector");
    wdog_vec_a: assert property (take && wdog_rst_req_i && !por_rst_req_i && !clkmon_rst_req_i
        |=> vec_addr_o == 16'hFFFA) else $error("bad watchdog vector");
    trap_low_a: assert property (take && trap_req_i && !rst_any |=> vec_addr_o[7:0] == 8'hF8)
        else $error("bad trap vector");
    debug_page_a: assert property (take && debug_firmware_mode_i |=> vec_addr_o[15:8] == 8'hFF)
        else $error("debug page not forced");
    spur_vec_a: assert property (take && !rst_any && !any_irq |=> vec_addr_o[7:0] == 8'h80)
        else $error("no spurious vector");
    wake_mask_a: assert property (i_mask_i && !trap_req_i && !soft_irq_req_i && (x_mask_i || !die_link_err_i)
        |-> !wake_o) else $error("masked wake");
    wake_link_a: assert property (!i_mask_i && die_link_irq_i |-> wake_o) else $error("missed wake");
    cover property (take && por_rst_req_i);
    cover property (take && debug_firmware_mode_i);
    cover property (take && !rst_any && |irq_i);
    cover property (wake_o && !i_mask_i);
endmodule
bind exvp_top exvp_checker #(.NUM_IRQ(NUM_IRQ)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .por_rst_req_i(por_rst_req_i), .clkmon_rst_req_i(clkmon_rst_req_i), .wdog_rst_req_i(wdog_rst_req_i),
    .trap_req_i(trap_req_i), .soft_irq_req_i(soft_irq_req_i), .die_link_err_i(die_link_err_i),
    .die_link_irq_i(die_link_irq_i), .irq_i(irq_i), .i_mask_i(i_mask_i), .x_mask_i(x_mask_i),
    .debug_firmware_mode_i(debug_firmware_mode_i), .vec_req_i(vec_req_i), .vec_addr_o(vec_addr_o),
    .vec_ack_o(vec_ack_o), .wake_o(wake_o));
`default_nettype wire

/* File: tb/exvp_cpu_model.sv */
// cpu side model: raises the vector request strobe and collects the vector
// assumes the vector port handshake of exvp_top
`timescale 1ns/1ps
`default_nettype none
module exvp_cpu_model (
    input  wire logic        clk_i,
    input  wire logic        vec_ack_o,
    input  wire logic [15:0] vec_addr_o,
    output var logic         vec_req_i
);
    initial vec_req_i = 1'h0;
    // hold > 0 mimics a slow cpu keeping the strobe up while stacking
    task automatic fetch(input int hold, output logic [15:0] v);
        @(posedge clk_i);
        vec_req_i <= 1'h1;
        do @(posedge clk_i); while (vec_ack_o !== 1'h1);
        repeat (hold) @(posedge clk_i);
        v = vec_addr_o;
        vec_req_i <= 1'h0;
        // strobe must be seen low before the next vector
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

/* File: tb/exvp_top_tb.sv */
// testbench: register bus, ranking, debug page, wake-up and reset of exvp_top
// assumes exvp_cpu_model as the cpu and the bound exvp_checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module exvp_top_tb;
    import exvp_pkg::*;
    localparam logic [55:0] Q0 = 56'h00_0000_0000_0001;
    localparam logic [55:0] QT = 56'h80_0000_0000_0000;
    localparam logic [7:0]  B  = 8'h12;
    logic        clk_i, rst_i, vec_req_i, vec_ack_o, wake_o;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        por_rst_req_i, clkmon_rst_req_i, wdog_rst_req_i, trap_req_i, soft_irq_req_i;
    logic        die_link_err_i, die_link_irq_i, i_mask_i, x_mask_i, debug_firmware_mode_i;
    logic [55:0] irq_i, irq_en_i;
    logic [15:0] vec_addr_o;
    int          n_tests, miscompares;
    exvp_top dut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .por_rst_req_i(por_rst_req_i), .clkmon_rst_req_i(clkmon_rst_req_i), .wdog_rst_req_i(wdog_rst_req_i),
        .trap_req_i(trap_req_i), .soft_irq_req_i(soft_irq_req_i), .die_link_err_i(die_link_err_i),
        .die_link_irq_i(die_link_irq_i), .irq_i(irq_i), .irq_en_i(irq_en_i), .i_mask_i(i_mask_i),
        .x_mask_i(x_mask_i), .debug_firmware_mode_i(debug_firmware_mode_i), .vec_req_i(vec_req_i),
        .vec_addr_o(vec_addr_o), .vec_ack_o(vec_ack_o), .wake_o(wake_o));
    exvp_cpu_model cpu (.clk_i(clk_i), .vec_ack_o(vec_ack_o), .vec_addr_o(vec_addr_o), .vec_req_i(vec_req_i));
    initial begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            @(posedge clk_i);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            @(posedge clk_i);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    // s = por, clkmon, wdog, trap, soft, link error, link irq; m = i mask, x mask, debug
    task automatic vcase(input logic [6:0] s, input logic [55:0] q, input logic [55:0] en,
                         input logic [2:0] m, input logic [15:0] e);
        logic [15:0] v;
        @(posedge clk_i);
        {por_rst_req_i, clkmon_rst_req_i, wdog_rst_req_i, trap_req_i, soft_irq_req_i} <= s[6:2];
        {die_link_err_i, die_link_irq_i} <= s[1:0];
        irq_i <= q;
        irq_en_i <= en;
        {i_mask_i, x_mask_i, debug_firmware_mode_i} <= m;
        cpu.fetch(n_tests % 3, v);
        `CHK(v, e)
    endtask
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(EXVP_OFF_BASE, d, r);
        `CHK(d, 32'h0000_00FF)
        axi_wr(EXVP_OFF_BASE, 32'h0000_0012, r);
        `CHK(r, EXVP_RESP_OKAY)
        // byte lane 0 off: the base byte must keep its value
        s_axi_wstrb <= 4'hE;
        axi_wr(EXVP_OFF_BASE, 32'h0000_0034, r);
        s_axi_wstrb <= 4'hF;
        axi_rd(EXVP_OFF_BASE, d, r);
        `CHK(d, 32'h0000_0012)
        axi_rd(8'h0C, d, r);
        `CHK(r, EXVP_RESP_SLV)
    endtask
    task automatic t_rank;
        vcase(7'h40, Q0, '1, 3'h0, {EXVP_TOP_PAGE, EXVP_LO_POR});
        vcase(7'h30, Q0, '1, 3'h0, {EXVP_TOP_PAGE, EXVP_LO_CLKMON});
        vcase(7'h18, Q0, '1, 3'h0, {EXVP_TOP_PAGE, EXVP_LO_WDOG});
        vcase(7'h0C, Q0, '1, 3'h0, {B, EXVP_LO_TRAP});
        vcase(7'h06, Q0, '1, 3'h6, {B, EXVP_LO_SOFT});
        vcase(7'h03, QT, '1, 3'h0, {B, EXVP_LO_XIRQ});
        vcase(7'h02, QT, '1, 3'h4, {B, EXVP_LO_XIRQ});
        vcase(7'h03, QT, '1, 3'h2, {B, EXVP_LO_LINK});
        vcase(7'h01, QT, '1, 3'h0, {B, EXVP_LO_LINK});
        vcase(7'h00, QT | Q0, '1, 3'h0, {B, 8'hF0});
        vcase(7'h00, Q0, '1, 3'h0, {B, EXVP_LO_MASK_LO});
        vcase(7'h00, 56'h00_0000_0000_0009, ~Q0, 3'h0, {B, 8'h88});
        vcase(7'h01, Q0, '1, 3'h4, {B, EXVP_LO_SPUR});
        vcase(7'h00, '0, '1, 3'h0, {B, EXVP_LO_SPUR});
        vcase(7'h04, '0, '1, 3'h1, {EXVP_TOP_PAGE, EXVP_LO_SOFT});
        vcase(7'h40, '0, '1, 3'h1, {EXVP_TOP_PAGE, EXVP_LO_POR});
    endtask
    // wake is pure gating: checked 1 ns after the inputs move, no edge in between
    task automatic wk(input logic [6:0] s, input logic [55:0] q, input logic [2:0] m, input logic e);
        @(posedge clk_i);
        {por_rst_req_i, clkmon_rst_req_i, wdog_rst_req_i, trap_req_i, soft_irq_req_i} <= s[6:2];
        {die_link_err_i, die_link_irq_i} <= s[1:0];
        irq_i <= q;
        {i_mask_i, x_mask_i, debug_firmware_mode_i} <= m;
        #1 `CHK(wake_o, e)
    endtask
    task automatic t_wake;
        wk(7'h00, Q0, 3'h0, 1'h1);
        wk(7'h00, Q0, 3'h4, 1'h0);
        wk(7'h03, '0, 3'h6, 1'h0);
        wk(7'h08, '0, 3'h4, 1'h1);
        wk(7'h00, '0, 3'h0, 1'h0);
    endtask
    task automatic t_rerst;
        logic [31:0] d;
        logic [1:0]  r;
        // last vector was the power-on one with debug set; wake inputs now idle
        axi_rd(EXVP_OFF_STATUS, d, r);
        `CHK(d, 32'hFFFE_0001)
        @(posedge clk_i);
        rst_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        axi_rd(EXVP_OFF_BASE, d, r);
        `CHK(d, 32'h0000_00FF)
        axi_rd(EXVP_OFF_STATUS, d, r);
        `CHK(d, 32'h0000_0000)
    endtask
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        complete_run();
    end
    initial begin
        n_tests = 0;
        miscompares = 0;
        rst_i = 1'h1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        {por_rst_req_i, clkmon_rst_req_i, wdog_rst_req_i, trap_req_i, soft_irq_req_i} = '0;
        {die_link_err_i, die_link_irq_i, i_mask_i, x_mask_i, debug_firmware_mode_i} = '0;
        irq_i = '0;
        irq_en_i = '1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        t_regs();
        t_rank();
        t_wake();
        t_rerst();
        complete_run();
    end
endmodule
`undef CHK
`default_nettype wire

/* File: verilog/exvp_pkg.sv */
// exception vector priority decoder: shared constants and types
// assumes a 32-bit axi4-lite register bus and a 16-bit vector bus to the cpu
package exvp_pkg;

    // register byte offsets
    localparam logic [7:0]  EXVP_OFF_BASE   = 8'h00;
    localparam logic [7:0]  EXVP_OFF_STATUS = 8'h04;
    localparam logic [7:0]  EXVP_OFF_PEND   = 8'h08;

    // vector base byte field and reset value
    localparam int          EXVP_BASE_W     = 8;
    localparam logic [7:0]  EXVP_BASE_RST   = 8'hFF;
    localparam logic [7:0]  EXVP_TOP_PAGE   = 8'hFF;
    localparam logic [7:0]  EXVP_LOW_ZERO   = 8'h00;

    // low bytes of the vector addresses
    localparam logic [7:0]  EXVP_LO_POR     = 8'hFE;
    localparam logic [7:0]  EXVP_LO_CLKMON  = 8'hFC;
    localparam logic [7:0]  EXVP_LO_WDOG    = 8'hFA;
    localparam logic [7:0]  EXVP_LO_TRAP    = 8'hF8;
    localparam logic [7:0]  EXVP_LO_SOFT    = 8'hF6;
    localparam logic [7:0]  EXVP_LO_XIRQ    = 8'hF4;
    localparam logic [7:0]  EXVP_LO_LINK    = 8'hF2;
    localparam logic [7:0]  EXVP_LO_MASK_LO = 8'h82;
    localparam logic [7:0]  EXVP_LO_SPUR    = 8'h80;

    // device specific maskable sources, 0x82 .. 0xf0 in steps of two
    localparam int          EXVP_NUM_IRQ    = 56;

    // status register field positions
    localparam int          EXVP_ST_VEC_LSB = 16;
    localparam int          EXVP_ST_RESET   = 0;
    localparam int          EXVP_ST_SPUR    = 1;
    localparam int          EXVP_ST_DEBUG   = 2;
    localparam int          EXVP_ST_WAKE    = 3;

    // axi responses
    localparam logic [1:0]  EXVP_RESP_OKAY  = 2'b00;
    localparam logic [1:0]  EXVP_RESP_SLV   = 2'b10;

    // which class of source won the ranking
    typedef enum logic [2:0] {
        EXVP_SRC_NONE  = 3'b000,
        EXVP_SRC_RESET = 3'b001,
        EXVP_SRC_TRAP  = 3'b011,
        EXVP_SRC_SOFT  = 3'b010,
        EXVP_SRC_XIRQ  = 3'b110,
        EXVP_SRC_IRQ   = 3'b111
    } exvp_src_t;

endpackage

/* File: verilog/exvp_rank.sv */
// exception vector priority decoder: fixed priority ranking of all requests
// purely combinational; caller samples the result at the vector request
`timescale 1ns/1ps
`default_nettype none
module exvp_rank
    import exvp_pkg::*;
#(
    parameter int NUM_IRQ = exvp_pkg::EXVP_NUM_IRQ
) (
    input  wire logic               por_rst_i,
    input  wire logic               clkmon_rst_i,
    input  wire logic               wdog_rst_i,
    input  wire logic               trap_req_i,
    input  wire logic               soft_req_i,
    input  wire logic               xirq_req_i,
    input  wire logic               link_irq_i,
    input  wire logic [NUM_IRQ-1:0] irq_i,
    input  wire logic [NUM_IRQ-1:0] irq_en_i,
    input  wire logic               i_mask_i,
    input  wire logic               x_mask_i,
    output exvp_pkg::exvp_src_t     src_o,
    output logic [7:0]              vec_lo_o
);
    import exvp_pkg::*;

    // highest qualified device source; higher index means higher address
    function automatic logic [7:0] irq_lo(input logic [NUM_IRQ-1:0] q);
        logic [7:0] lo;
        lo = EXVP_LO_SPUR;
        for (int k = 0; k < NUM_IRQ; k++) begin
            if (q[k]) begin
                lo = EXVP_LO_MASK_LO + 8'(2 * k);
            end
        end
        return lo;
    endfunction

    logic [NUM_IRQ-1:0] irq_q;
    logic               xirq_q;
    logic               i_ok;

    assign xirq_q = xirq_req_i & ~x_mask_i;
    // ordinary sources only with i flag clear, nothing above; device sources also need local enable
    assign i_ok   = ~i_mask_i & ~trap_req_i & ~soft_req_i & ~xirq_q;
    assign irq_q  = irq_i & irq_en_i & {NUM_IRQ{i_ok}};

    always_comb begin
        src_o    = EXVP_SRC_NONE;
        vec_lo_o = EXVP_LO_SPUR;
        // higher vector address wins throughout
        if (por_rst_i) begin
            src_o    = EXVP_SRC_RESET;
            vec_lo_o = EXVP_LO_POR;
        end else if (clkmon_rst_i) begin
            src_o    = EXVP_SRC_RESET;
            vec_lo_o = EXVP_LO_CLKMON;
        end else if (wdog_rst_i) begin
            src_o    = EXVP_SRC_RESET;
            vec_lo_o = EXVP_LO_WDOG;
        end else if (trap_req_i) begin
            src_o    = EXVP_SRC_TRAP;
            vec_lo_o = EXVP_LO_TRAP;
        end else if (soft_req_i) begin
            src_o    = EXVP_SRC_SOFT;
            vec_lo_o = EXVP_LO_SOFT;
        end else if (xirq_q) begin
            src_o    = EXVP_SRC_XIRQ;
            vec_lo_o = EXVP_LO_XIRQ;
        end else if (link_irq_i & i_ok) begin
            src_o    = EXVP_SRC_IRQ;
            vec_lo_o = EXVP_LO_LINK;
        end else if (|irq_q) begin
            src_o    = EXVP_SRC_IRQ;
            vec_lo_o = irq_lo(irq_q);
        end
    end

endmodule
`default_nettype wire

/* File: verilog/exvp_top.sv */
// exception vector priority decoder: register bank, vector sampling, wake-up
// assumes request inputs synchronous to clk_i except on the wake path,
// and an axi4-lite master issuing at most one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
// How it works
// - eight-bit base forms vector upper byte
// - reset loads base byte with ones
// - reset vectors ignore the base byte
// - debug firmware forces upper byte ones
// - base byte readable and writable anytime
// - unmasked requests outrank i-masked requests
// - x request preempts ordinary service routine
// - higher vector address wins
// - ordinary request needs clear flag, device request also enable
// - rank evaluated at the vector request
// - nothing qualified gives spurious vector
// - three reset vectors on top
// - trap and soft vectors non-maskable
// - die-link error x-maskable, link irq ordinary
// - device sources 0xf0 down to 0x82
// - every supplied vector is sixteen bits
// - qualified ordinary request wakes from stop
// - i flag blocks ordinary wake-ups
// - stop wake path needs no clock
// - vector base is byte then zero
// - clock gated in low power, wake works
module exvp_top
    import exvp_pkg::*;
#(
    parameter int NUM_IRQ = exvp_pkg::EXVP_NUM_IRQ,
    parameter int ADDR_W  = 8
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // exception requests
    input  wire logic               por_rst_req_i,
    input  wire logic               clkmon_rst_req_i,
    input  wire logic               wdog_rst_req_i,
    input  wire logic               trap_req_i,
    input  wire logic               soft_irq_req_i,
    input  wire logic               die_link_err_i,
    input  wire logic               die_link_irq_i,
    input  wire logic [NUM_IRQ-1:0] irq_i,
    input  wire logic [NUM_IRQ-1:0] irq_en_i,
    // cpu side
    input  wire logic               i_mask_i,
    input  wire logic               x_mask_i,
    input  wire logic               debug_firmware_mode_i,
    input  wire logic               vec_req_i,
    output logic [15:0]             vec_addr_o,
    output logic                    vec_ack_o,
    output logic                    wake_o
);
    import exvp_pkg::*;

    typedef struct packed {
        logic [7:0]  base;
        logic [15:0] vec;
        logic        ack;
        logic        spur;
        logic        rst_hit;
        logic        aw_have;
        logic [7:0]  aw_off;
        logic        aw_rdy;
        logic        w_have;
        logic [7:0]  w_byte;
        logic        w_lane0;
        logic        w_rdy;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        ar_rdy;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } exvp_state_t;

    exvp_state_t st_reg;
    exvp_state_t st_next;

    exvp_src_t  src;
    logic [7:0] vec_lo;
    logic [7:0] upper;
    logic       wake_q;

    exvp_rank #(
        .NUM_IRQ (NUM_IRQ)
    ) u_rank (
        .por_rst_i    (por_rst_req_i),
        .clkmon_rst_i (clkmon_rst_req_i),
        .wdog_rst_i   (wdog_rst_req_i),
        .trap_req_i   (trap_req_i),
        .soft_req_i   (soft_irq_req_i),
        .xirq_req_i   (die_link_err_i),
        .link_irq_i   (die_link_irq_i),
        .irq_i        (irq_i),
        .irq_en_i     (irq_en_i),
        .i_mask_i     (i_mask_i),
        .x_mask_i     (x_mask_i),
        .src_o        (src),
        .vec_lo_o     (vec_lo)
    );

    // upper byte choice; reset vectors live on the top page always
    always_comb begin
        if (src == EXVP_SRC_RESET) begin
            upper = EXVP_TOP_PAGE;
        end else if (debug_firmware_mode_i) begin
            upper = EXVP_TOP_PAGE;
        end else begin
            upper = st_reg.base;
        end
    end

    // wake path is pure gating so it works with the clock stopped
    assign wake_q = ((~i_mask_i & ((|(irq_i & irq_en_i)) | die_link_irq_i))
                    | (~x_mask_i & die_link_err_i)
                    | trap_req_i
                    | soft_irq_req_i);
    assign wake_o = wake_q;

    // read mux for the single axi read path
    function automatic logic [31:0] read_word(input logic [7:0] off, input exvp_state_t s);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (off)
            EXVP_OFF_BASE: d[7:0] = s.base;
            EXVP_OFF_STATUS: begin
                d[EXVP_ST_VEC_LSB +: 16] = s.vec;
                d[EXVP_ST_RESET]         = s.rst_hit;
                d[EXVP_ST_SPUR]          = s.spur;
                d[EXVP_ST_DEBUG]         = debug_firmware_mode_i;
                d[EXVP_ST_WAKE]          = wake_q;
            end
            EXVP_OFF_PEND: d[7:0] = {2'b00, src, vec_lo[7:5]};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    function automatic logic mapped(input logic [7:0] off);
        return (off == EXVP_OFF_BASE) || (off == EXVP_OFF_STATUS) || (off == EXVP_OFF_PEND);
    endfunction

    always_comb begin
        st_next = st_reg;

        // vector handshake: sample once per strobe, hold until it drops
        if (vec_req_i && !st_reg.ack) begin
            st_next.vec     = {upper, vec_lo};
            st_next.ack     = 1'b1;
            st_next.spur    = (src == EXVP_SRC_NONE);
            st_next.rst_hit = (src == EXVP_SRC_RESET);
        end else if (!vec_req_i) begin
            st_next.ack = 1'b0;
        end

        // write address and data may come in either order
        if (s_axi_awvalid && st_reg.aw_rdy) begin
            st_next.aw_have = 1'b1;
            st_next.aw_off  = 8'(s_axi_awaddr);
        end
        if (s_axi_wvalid && st_reg.w_rdy) begin
            st_next.w_have  = 1'b1;
            st_next.w_byte  = s_axi_wdata[7:0];
            st_next.w_lane0 = s_axi_wstrb[0];
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = mapped(st_reg.aw_off) ? EXVP_RESP_OKAY : EXVP_RESP_SLV;
            if (st_reg.aw_off == EXVP_OFF_BASE && st_reg.w_lane0) begin
                st_next.base = st_reg.w_byte;
            end
        end
        st_next.aw_rdy = !st_next.aw_have;
        st_next.w_rdy  = !st_next.w_have;

        // read: one-cycle answer, held until taken
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_reg.ar_rdy) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = read_word(8'(s_axi_araddr), st_reg);
            st_next.rresp  = mapped(8'(s_axi_araddr)) ? EXVP_RESP_OKAY : EXVP_RESP_SLV;
        end
        st_next.ar_rdy = !st_next.rvalid;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg        <= '0;
            st_reg.base   <= EXVP_BASE_RST;
            st_reg.aw_rdy <= 1'b1;
            st_reg.w_rdy  <= 1'b1;
            st_reg.ar_rdy <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = st_reg.aw_rdy;
    assign s_axi_wready  = st_reg.w_rdy;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = st_reg.ar_rdy;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    assign vec_addr_o    = st_reg.vec;
    assign vec_ack_o     = st_reg.ack;

endmodule
`default_nettype wire
